// file: axc_unit.sv
`default_nettype none
module axc_unit
   import axc_pkg::*;
(
   // Clock and reset
   input  wire logic               clk_in,
   input  wire logic               reset_in,
   // Instruction from the sequencer
   input  wire logic               instr_valid_in,
   input  wire axc_instr_t         instr_in,
   output logic                    instr_ready_out,
   output logic                    done_out,
   // Accumulator load from the sequencer
   input  wire logic               acc_load_in,
   input  wire logic [ACC_W-1:0]   acc_load_data_in,
   // Word memory read port
   output logic                    wmem_rd_out,
   output logic      [ADDR_W-1:0]  wmem_addr_out,
   input  wire logic [WORD_W-1:0]  wmem_data_in,
   // Discrete bit memory read port
   output logic                    bmem_rd_out,
   output logic      [ADDR_W-1:0]  bmem_addr_out,
   input  wire logic               bmem_data_in,
   // Datapath state
   output logic      [ACC_W-1:0]   accum_out,
   output axc_flags_t              flags_out,
   output logic      [DEPTH_W-1:0] stack_depth_out,
   // Register port
   input  wire logic [REG_AW-1:0]  reg_addr_in,
   input  wire logic [ACC_W-1:0]   reg_wdata_in,
   input  wire logic               reg_wr_in,
   input  wire logic               reg_rd_in,
   output logic      [ACC_W-1:0]   reg_rdata_out,
   // Interrupt
   output logic                    irq_out
);
   axc_state_t        state;
   axc_state_t        next_state;
   axc_op_t           op_q;
   axc_op_t           next_op;
   logic              imm_q;
   logic              next_imm;
   logic [ADDR_W-1:0] addr_q;
   logic [ADDR_W-1:0] next_addr;
   logic [CNT_W-1:0]  cnt_q;
   logic [CNT_W-1:0]  next_cnt;
   logic [CNT_W-1:0]  issue_q;
   logic [CNT_W-1:0]  next_issue;
   logic [CNT_W-1:0]  got_q;
   logic [CNT_W-1:0]  next_got;
   logic              bpend_q;
   logic [ACC_W-1:0]  opnd;
   logic [ACC_W-1:0]  next_opnd;
   logic [ACC_W-1:0]  exec_opnd;
   logic [ACC_W-1:0]  acc;
   logic [ACC_W-1:0]  next_acc;
   axc_flags_t        flags;
   axc_flags_t        next_flags;
   logic              done_q;
   logic              next_done;
   logic              enable;
   logic              next_enable;
   logic [ACC_W-1:0]  rdata;
   logic [ACC_W-1:0]  next_rdata;
   logic              stack_push;
   logic              stack_pop;
   logic [ACC_W-1:0]  stack_top;
   logic [DEPTH_W-1:0] stack_depth;
   logic              stack_underflow;
   logic [EVT_W-1:0]  events;
   logic [EVT_W-1:0]  irq_status;
   logic [EVT_W-1:0]  irq_enable;
   logic [ACC_W-1:0]  xor_result;
   logic [WORD_W-1:0] cmp_acc;
   logic [WORD_W-1:0] cmp_mem;

   assign instr_ready_out = (state == st_idle) && enable;

   // Operand as seen in the execute cycle
   always_comb begin
      exec_opnd = opnd;
      unique case (op_q)
         xor_double_op: begin
            exec_opnd = imm_q ? opnd : {wmem_data_in, opnd[WORD_W-1:0]};
         end
         xor_stack_op: begin
            exec_opnd = stack_top;
         end
         compare_word_op: begin
            exec_opnd = {16'h0000, wmem_data_in};
         end
         default: begin
            exec_opnd = opnd;
         end
      endcase
   end

   assign xor_result = acc ^ exec_opnd;
   assign cmp_acc    = acc[WORD_W-1:0];
   assign cmp_mem    = exec_opnd[WORD_W-1:0];

   // Sequencer and datapath
   always_comb begin
      next_state    = state;
      next_op       = op_q;
      next_imm      = imm_q;
      next_addr     = addr_q;
      next_cnt      = cnt_q;
      next_issue    = issue_q;
      next_got      = got_q;
      next_opnd     = opnd;
      next_acc      = acc;
      next_flags    = flags;
      next_done     = 1'b0;
      stack_push    = 1'b0;
      stack_pop     = 1'b0;
      wmem_rd_out   = 1'b0;
      wmem_addr_out = addr_q;
      bmem_rd_out   = 1'b0;
      bmem_addr_out = addr_q + ADDR_W'(issue_q);
      unique case (state)
         st_idle: begin
            if (instr_valid_in && enable) begin
               next_op    = instr_in.op;
               next_imm   = instr_in.imm_sel;
               next_addr  = instr_in.addr;
               next_cnt   = axc_clamp_count(instr_in.count);
               next_issue = 6'h00;
               next_got   = 6'h00;
               next_opnd  = instr_in.imm;
               unique case (instr_in.op)
                  xor_double_op: begin
                     next_state = instr_in.imm_sel ? st_exec : st_rd_lo;
                  end
                  xor_formatted_op: begin
                     next_opnd  = ACC_RESET;
                     next_state = st_bits;
                  end
                  xor_stack_op: begin
                     next_state = st_exec;
                  end
                  compare_word_op: begin
                     next_state = st_rd_lo;
                  end
                  default: begin
                     next_state = st_idle;
                  end
               endcase
            end else if (acc_load_in) begin
               next_acc   = acc_load_data_in;
               stack_push = 1'b1;
            end
         end
         st_rd_lo: begin
            wmem_rd_out   = 1'b1;
            wmem_addr_out = addr_q;
            next_state    = (op_q == compare_word_op) ? st_exec : st_rd_hi;
         end
         st_rd_hi: begin
            wmem_rd_out             = 1'b1;
            wmem_addr_out           = addr_q + 16'h0001;
            next_opnd[WORD_W-1:0]   = wmem_data_in;
            next_state              = st_exec;
         end
         st_bits: begin
            if (issue_q < cnt_q) begin
               bmem_rd_out = 1'b1;
               next_issue  = issue_q + 6'h01;
            end
            if (bpend_q) begin
               next_opnd[got_q[4:0]] = bmem_data_in;
               next_got              = got_q + 6'h01;
               if (got_q + 6'h01 == cnt_q) begin
                  next_state = st_exec;
               end
            end
         end
         st_exec: begin
            next_opnd  = exec_opnd;
            next_done  = 1'b1;
            next_state = st_idle;
            if (op_q == compare_word_op) begin
               // Raw unsigned compare, no conversion of encoding
               next_flags.less_than_flag    = cmp_acc < cmp_mem;
               next_flags.equal_flag        = cmp_acc == cmp_mem;
               next_flags.greater_than_flag = cmp_acc > cmp_mem;
            end else begin
               next_acc                        = xor_result;
               next_flags.zero_result_flag     = xor_result == ACC_RESET;
               next_flags.negative_result_flag = xor_result[ACC_W-1];
               stack_pop                       = (op_q == xor_stack_op);
            end
         end
         default: begin
            next_state = st_idle;
         end
      endcase
   end

   always_ff @(posedge clk_in) begin
      if (reset_in) begin
         state   <= st_idle;
         op_q    <= no_op;
         imm_q   <= 1'b0;
         addr_q  <= 16'h0000;
         cnt_q   <= FMT_MIN;
         issue_q <= 6'h00;
         got_q   <= 6'h00;
         bpend_q <= 1'b0;
         opnd    <= ACC_RESET;
         acc     <= ACC_RESET;
         flags   <= FLAGS_RESET;
         done_q  <= 1'b0;
      end else begin
         state   <= next_state;
         op_q    <= next_op;
         imm_q   <= next_imm;
         addr_q  <= next_addr;
         cnt_q   <= next_cnt;
         issue_q <= next_issue;
         got_q   <= next_got;
         bpend_q <= bmem_rd_out;
         opnd    <= next_opnd;
         acc     <= next_acc;
         flags   <= next_flags;
         done_q  <= next_done;
      end
   end

   assign done_out        = done_q;
   assign accum_out       = acc;
   assign flags_out       = flags;
   assign stack_depth_out = stack_depth;

   axc_stack u_stack (
      .clk_in        (clk_in),
      .reset_in      (reset_in),
      .push_in       (stack_push),
      .push_data_in  (acc),
      .pop_in        (stack_pop),
      .top_out       (stack_top),
      .depth_out     (stack_depth),
      .underflow_out (stack_underflow)
   );

   assign events[EVT_XOR]       = (state == st_exec) && axc_is_xor(op_q);
   assign events[EVT_CMP]       = (state == st_exec) && (op_q == compare_word_op);
   assign events[EVT_UNDERFLOW] = stack_underflow;

   axc_irq u_irq (
      .clk_in       (clk_in),
      .reset_in     (reset_in),
      .event_in     (events),
      .clear_wr_in  (reg_wr_in && (reg_addr_in == REG_IRQ_CLEAR)),
      .enable_wr_in (reg_wr_in && (reg_addr_in == REG_IRQ_ENABLE)),
      .wdata_in     (reg_wdata_in[EVT_W-1:0]),
      .status_out   (irq_status),
      .enable_out   (irq_enable),
      .irq_out      (irq_out)
   );

   // Register port
   always_comb begin
      next_enable = enable;
      next_rdata  = '0;
      if (reg_wr_in && (reg_addr_in == REG_CTRL)) begin
         next_enable = reg_wdata_in[CTRL_EN_BIT];
      end
      if (reg_rd_in) begin
         unique case (reg_addr_in)
            REG_ACC:        next_rdata = acc;
            REG_FLAGS:      next_rdata = {27'h0000000, flags};
            REG_IRQ_STATUS: next_rdata = {29'h00000000, irq_status};
            REG_IRQ_ENABLE: next_rdata = {29'h00000000, irq_enable};
            REG_CTRL:       next_rdata = {31'h00000000, enable};
            REG_STACK:      next_rdata = {28'h0000000, stack_depth};
            default:        next_rdata = '0;
         endcase
      end
   end

   always_ff @(posedge clk_in) begin
      if (reset_in) begin
         enable <= CTRL_EN_RESET;
         rdata  <= '0;
      end else begin
         enable <= next_enable;
         rdata  <= next_rdata;
      end
   end

   assign reg_rdata_out = rdata;

   default clocking cb @(posedge clk_in); endclocking
   default disable iff (reset_in);

   AST_XOR_DOUBLE: assert property (
      done_q && (op_q == xor_double_op) |-> acc == ($past(acc) ^ opnd))
      else $error("double xor result wrong");
   AST_DOUBLE_FETCH: assert property (
      (state == st_rd_lo) && (op_q == xor_double_op) |=> wmem_rd_out
         && (wmem_addr_out == $past(wmem_addr_out) + 16'h0001) ##1 (state == st_exec))
      else $error("double operand fetch order wrong");
   AST_ZERO_FLAG: assert property (
      done_q && axc_is_xor(op_q) |-> flags.zero_result_flag == (acc == ACC_RESET))
      else $error("zero flag wrong after xor");
   AST_NEG_FLAG: assert property (
      done_q && axc_is_xor(op_q) |-> flags.negative_result_flag == acc[ACC_W-1])
      else $error("negative flag wrong after xor");
   AST_FLAG_HOLD: assert property (
      !done_q |-> $stable(flags))
      else $error("flags changed without an instruction");
   AST_FMT_WIDTH: assert property (
      done_q && (op_q == xor_formatted_op) |-> ((opnd >> cnt_q) == ACC_RESET)
         && (cnt_q >= FMT_MIN) && (cnt_q <= FMT_MAX))
      else $error("formatted operand wider than bit count");
   AST_FMT_GATHER: assert property (
      (state == st_idle) ##1 (state == st_bits) |-> bmem_rd_out
         && (bmem_addr_out == addr_q) ##[1:34] (state == st_exec))
      else $error("bit gather did not start or finish");
   AST_XOR_STACK: assert property (
      (state == st_exec) && (op_q == xor_stack_op) |=> acc == ($past(acc) ^ $past(stack_top)))
      else $error("stack xor result wrong");
   AST_STACK_POP: assert property (
      (state == st_exec) && (op_q == xor_stack_op) && (stack_depth != 4'h0)
         |=> stack_depth == $past(stack_depth) - 4'h1)
      else $error("stack not popped");
   AST_CMP_LT: assert property (
      (state == st_exec) && (op_q == compare_word_op)
         |=> flags.less_than_flag == ($past(acc[WORD_W-1:0]) < $past(wmem_data_in)))
      else $error("less-than flag wrong");
   AST_CMP_EQ_GT: assert property (
      (state == st_exec) && (op_q == compare_word_op)
         |=> (flags.equal_flag == ($past(acc[WORD_W-1:0]) == $past(wmem_data_in)))
         && (flags.greater_than_flag == ($past(acc[WORD_W-1:0]) > $past(wmem_data_in))))
      else $error("equal or greater-than flag wrong");
   AST_CMP_ONEHOT: assert property (
      done_q && (op_q == compare_word_op) |-> $onehot({flags.less_than_flag,
         flags.equal_flag, flags.greater_than_flag}) && $stable(acc) && $stable(stack_depth))
      else $error("compare flags not one-hot or state disturbed");
   AST_FLAG_SEPARATE: assert property (
      done_q |-> (axc_is_xor(op_q) ? $stable(flags[2:0]) : $stable(flags[4:3])))
      else $error("instruction touched foreign flags");
endmodule
`default_nettype wire

// file: axc_pkg.sv
`default_nettype none
package axc_pkg;
   // Datapath widths and sizes
   localparam int ACC_W       = 32;
   localparam int WORD_W      = 16;
   localparam int ADDR_W      = 16;
   localparam int CNT_W       = 6;
   localparam int STACK_DEPTH = 8;
   localparam int DEPTH_W     = 4;
   localparam int REG_AW      = 8;
   localparam int EVT_W       = 3;

   // Register offsets
   localparam logic [REG_AW-1:0] REG_ACC        = 8'h00;
   localparam logic [REG_AW-1:0] REG_FLAGS      = 8'h04;
   localparam logic [REG_AW-1:0] REG_IRQ_STATUS = 8'h08;
   localparam logic [REG_AW-1:0] REG_IRQ_CLEAR  = 8'h0c;
   localparam logic [REG_AW-1:0] REG_IRQ_ENABLE = 8'h10;
   localparam logic [REG_AW-1:0] REG_CTRL       = 8'h14;
   localparam logic [REG_AW-1:0] REG_STACK      = 8'h18;

   // Field positions and reset values
   localparam int CTRL_EN_BIT          = 0;
   localparam logic CTRL_EN_RESET      = 1'b1;
   localparam logic [EVT_W-1:0] IRQ_EN_RESET = 3'h0;
   localparam int EVT_XOR              = 0;
   localparam int EVT_CMP              = 1;
   localparam int EVT_UNDERFLOW        = 2;
   localparam logic [CNT_W-1:0] FMT_MIN = 6'h01;
   localparam logic [CNT_W-1:0] FMT_MAX = 6'h20;
   localparam logic [ACC_W-1:0] ACC_RESET = 32'h0000_0000;

   typedef enum logic [2:0] {
      no_op            = 3'h0,
      xor_double_op    = 3'h1,
      xor_formatted_op = 3'h2,
      xor_stack_op     = 3'h3,
      compare_word_op  = 3'h4
   } axc_op_t;

   typedef enum logic [2:0] {
      st_idle  = 3'b000,
      st_rd_lo = 3'b001,
      st_rd_hi = 3'b011,
      st_bits  = 3'b010,
      st_exec  = 3'b110
   } axc_state_t;

   typedef struct packed {
      axc_op_t           op;
      logic              imm_sel;
      logic [ADDR_W-1:0] addr;
      logic [ACC_W-1:0]  imm;
      logic [CNT_W-1:0]  count;
   } axc_instr_t;

   typedef struct packed {
      logic negative_result_flag;
      logic zero_result_flag;
      logic greater_than_flag;
      logic equal_flag;
      logic less_than_flag;
   } axc_flags_t;

   localparam axc_flags_t FLAGS_RESET = 5'h00;

   function automatic logic [CNT_W-1:0] axc_clamp_count(input logic [CNT_W-1:0] c);
      logic [CNT_W-1:0] r;
      r = c;
      if (c < FMT_MIN) begin
         r = FMT_MIN;
      end else if (c > FMT_MAX) begin
         r = FMT_MAX;
      end
      return r;
   endfunction

   function automatic logic axc_is_xor(input axc_op_t op);
      return (op == xor_double_op) || (op == xor_formatted_op) || (op == xor_stack_op);
   endfunction
endpackage
`default_nettype wire

// file: axc_stack.sv
`default_nettype none
module axc_stack
   import axc_pkg::*;
(
   // Clock and reset
   input  wire logic               clk_in,
   input  wire logic               reset_in,
   // Push and pop
   input  wire logic               push_in,
   input  wire logic [ACC_W-1:0]   push_data_in,
   input  wire logic               pop_in,
   // State
   output logic      [ACC_W-1:0]   top_out,
   output logic      [DEPTH_W-1:0] depth_out,
   output logic                    underflow_out
);
   logic [ACC_W-1:0]   level      [STACK_DEPTH];
   logic [ACC_W-1:0]   next_level [STACK_DEPTH];
   logic [DEPTH_W-1:0] depth;
   logic [DEPTH_W-1:0] next_depth;

   always_comb begin
      next_level = level;
      next_depth = depth;
      if (push_in) begin
         for (int i = STACK_DEPTH - 1; i > 0; i--) begin
            next_level[i] = level[i-1];
         end
         next_level[0] = push_data_in;
         if (depth != DEPTH_W'(STACK_DEPTH)) begin
            next_depth = depth + 4'h1;
         end
      end else if (pop_in) begin
         // Entries move one level toward the top
         for (int i = 0; i < STACK_DEPTH - 1; i++) begin
            next_level[i] = level[i+1];
         end
         next_level[STACK_DEPTH-1] = ACC_RESET;
         if (depth != 4'h0) begin
            next_depth = depth - 4'h1;
         end
      end
   end

   always_ff @(posedge clk_in) begin
      if (reset_in) begin
         for (int i = 0; i < STACK_DEPTH; i++) begin
            level[i] <= ACC_RESET;
         end
         depth <= 4'h0;
      end else begin
         level <= next_level;
         depth <= next_depth;
      end
   end

   assign top_out       = level[0];
   assign depth_out     = depth;
   assign underflow_out = pop_in && !push_in && (depth == 4'h0);
endmodule
`default_nettype wire

// file: axc_irq.sv
`default_nettype none
module axc_irq
   import axc_pkg::*;
(
   // Clock and reset
   input  wire logic             clk_in,
   input  wire logic             reset_in,
   // Events and software access
   input  wire logic [EVT_W-1:0] event_in,
   input  wire logic             clear_wr_in,
   input  wire logic             enable_wr_in,
   input  wire logic [EVT_W-1:0] wdata_in,
   // State
   output logic      [EVT_W-1:0] status_out,
   output logic      [EVT_W-1:0] enable_out,
   output logic                  irq_out
);
   logic [EVT_W-1:0] status;
   logic [EVT_W-1:0] enable;
   logic [EVT_W-1:0] next_status;
   logic [EVT_W-1:0] next_enable;

   always_comb begin
      next_status = status;
      next_enable = enable;
      // A new event wins over a clear in the same cycle
      if (clear_wr_in) begin
         next_status = status & ~wdata_in;
      end
      next_status = next_status | event_in;
      if (enable_wr_in) begin
         next_enable = wdata_in;
      end
   end

   always_ff @(posedge clk_in) begin
      if (reset_in) begin
         status <= '0;
         enable <= IRQ_EN_RESET;
      end else begin
         status <= next_status;
         enable <= next_enable;
      end
   end

   assign status_out = status;
   assign enable_out = enable;
   assign irq_out    = |(status & enable);
endmodule
`default_nettype wire

// file: accum_xor_compare_unit_bench.sv
`default_nettype none
module accum_xor_compare_unit_bench
   import axc_pkg::*;
;
   timeunit 1ns;
   timeprecision 1ps;

   typedef struct packed {
      logic [ACC_W-1:0]   acc;
      axc_flags_t         f;
      logic [DEPTH_W-1:0] d;
   } axc_exp_t;

   logic               clk_in, reset_in, instr_valid_in, acc_load_in, reg_wr_in, reg_rd_in;
   logic               instr_ready_out, done_out, wmem_rd_out, bmem_rd_out, irq_out;
   logic               bmem_data_in = 1'b0;
   logic [WORD_W-1:0]  wmem_data_in = '0;
   axc_instr_t         instr_in;
   axc_flags_t         flags_out, fm;
   logic [ACC_W-1:0]   acc_load_data_in, accum_out, reg_wdata_in, reg_rdata_out, am;
   logic [ADDR_W-1:0]  wmem_addr_out, bmem_addr_out;
   logic [DEPTH_W-1:0] stack_depth_out;
   logic [CNT_W-1:0]   fcnt [6] = '{6'h00, 6'h01, 6'h07, 6'h1f, 6'h20, 6'h21};
   logic [REG_AW-1:0]  reg_addr_in;
   logic [WORD_W-1:0]  wm [16];
   logic [63:0]        bm;
   logic [ACC_W-1:0]   stk [$];
   logic [ACC_W-1:0]   rq [$];
   axc_exp_t           iq [$];
   axc_exp_t           e;
   logic               rd_pend = 1'b0;
   int                 err_total = 0;
   int                 num_checks = 0;
   int                 cyc = 0;

   axc_unit DUT (.clk_in, .reset_in, .instr_valid_in, .instr_in, .instr_ready_out, .done_out,
      .acc_load_in, .acc_load_data_in, .wmem_rd_out, .wmem_addr_out, .wmem_data_in,
      .bmem_rd_out, .bmem_addr_out, .bmem_data_in, .accum_out, .flags_out, .stack_depth_out,
      .reg_addr_in, .reg_wdata_in, .reg_wr_in, .reg_rd_in, .reg_rdata_out, .irq_out);

   initial begin
      clk_in = 1'b0;
      forever #20 clk_in = ~clk_in;
   end

   task automatic chk(input string nm, input logic [ACC_W-1:0] x, input logic [ACC_W-1:0] g);
      num_checks++;
      if (g !== x) begin
         err_total++;
         $display("MISMATCH %s expected %h seen %h", nm, x, g);
      end
   endtask

   task automatic end_sim;
      // Expectations never answered count as a failure
      if (iq.size() != 0 || rq.size() != 0) err_total++;
      $display("checks %0d mismatches %0d", num_checks, err_total);
      if (err_total == 0 && num_checks > 0) begin
         $display("No errors found");
      end else begin
         $display("Errors were found");
      end
      $finish;
   endtask

   // Memories answer one cycle after the strobe, else show a toggling pattern
   always @(posedge clk_in) begin
      wmem_data_in <= (wmem_rd_out === 1'b1) ? wm[wmem_addr_out[3:0]] : ~wmem_data_in;
      bmem_data_in <= (bmem_rd_out === 1'b1) ? bm[bmem_addr_out[5:0]] : ~bmem_data_in;
   end

   always @(posedge clk_in) begin
      cyc++;
      if (rd_pend) chk("reg read", rq.pop_front(), reg_rdata_out);
      else if (reset_in === 1'b0) chk("idle rdata", '0, reg_rdata_out);
      rd_pend = (reg_rd_in === 1'b1);
      if (done_out === 1'b1) begin
         e = iq.pop_front();
         chk("accum", e.acc, accum_out);
         chk("flags", 32'(e.f), 32'(flags_out));
         chk("depth", 32'(e.d), 32'(stack_depth_out));
      end
      if (cyc > 4000) begin
         err_total++;
         end_sim();
      end
   end

   task automatic wr(input logic [REG_AW-1:0] a, input logic [ACC_W-1:0] d);
      reg_addr_in  <= a;
      reg_wdata_in <= d;
      reg_wr_in    <= 1'b1;
      @(posedge clk_in);
      reg_wr_in <= 1'b0;
      @(posedge clk_in);
   endtask

   task automatic rd(input logic [REG_AW-1:0] a, input logic [ACC_W-1:0] x);
      rq.push_back(x);
      reg_addr_in <= a;
      reg_rd_in   <= 1'b1;
      @(posedge clk_in);
      reg_rd_in <= 1'b0;
      @(posedge clk_in);
   endtask

   task automatic ld(input logic [ACC_W-1:0] d);
      acc_load_in      <= 1'b1;
      acc_load_data_in <= d;
      @(posedge clk_in);
      acc_load_in <= 1'b0;
      stk.push_front(am);
      if (stk.size() > STACK_DEPTH) void'(stk.pop_back());
      am = d;
      @(posedge clk_in);
   endtask

   task automatic go(input axc_op_t op, input logic [ADDR_W-1:0] a,
                     input logic [ACC_W-1:0] imm, input logic isel, input logic [CNT_W-1:0] c);
      logic [ACC_W-1:0] opd;
      int               n;
      opd = imm;
      n = (c == 0) ? 1 : (c > 32) ? 32 : int'(c);
      if (op == xor_double_op && !isel) opd = {wm[4'(a + 1)], wm[4'(a)]};
      if (op == xor_formatted_op) begin
         opd = '0;
         for (int i = 0; i < n; i++) opd[i] = bm[6'(a + i)];
      end
      if (op == xor_stack_op) opd = (stk.size() > 0) ? stk.pop_front() : '0;
      if (op == compare_word_op) begin
         fm.less_than_flag    = am[15:0] < wm[4'(a)];
         fm.equal_flag        = am[15:0] == wm[4'(a)];
         fm.greater_than_flag = am[15:0] > wm[4'(a)];
      end else begin
         am = am ^ opd;
         fm.zero_result_flag     = (am == '0);
         fm.negative_result_flag = am[31];
      end
      iq.push_back('{am, fm, DEPTH_W'(stk.size())});
      instr_in       <= '{op, isel, a, imm, c};
      instr_valid_in <= 1'b1;
      do @(posedge clk_in); while (instr_ready_out !== 1'b1);
      instr_valid_in <= 1'b0;
      for (int k = 0; k < 40 && done_out !== 1'b1; k++) @(posedge clk_in);
   endtask

   initial begin
      void'($urandom(32'h9bdcd29a));
      {instr_valid_in, acc_load_in, reg_wr_in, reg_rd_in} = '0;
      instr_in = '0;
      acc_load_data_in = '0;
      reg_addr_in = '0;
      reg_wdata_in = '0;
      am = '0;
      fm = '0;
      for (int i = 0; i < 16; i++) wm[i] = WORD_W'($urandom);
      bm = {$urandom, $urandom};
      reset_in = 1'b1;
      repeat (10) @(posedge clk_in);
      reset_in <= 1'b0;
      rd(REG_CTRL, 32'h0000_0001);
      rd(REG_IRQ_ENABLE, 32'h0000_0000);
      ld($urandom);
      go(xor_double_op, 16'h0000, $urandom, 1'b1, 6'h00);
      go(xor_double_op, 16'h0005, $urandom, 1'b0, 6'h00);
      go(xor_double_op, 16'h0000, am, 1'b1, 6'h00);
      go(xor_double_op, 16'h0000, 32'h8000_0001, 1'b1, 6'h00);
      $display("test xor_double done");
      foreach (fcnt[j]) begin
         go(xor_formatted_op, ADDR_W'($urandom), $urandom, 1'b0, fcnt[j]);
      end
      $display("test xor_formatted done");
      for (int i = 0; i < 9; i++) ld($urandom);
      for (int i = 0; i < 10; i++) go(xor_stack_op, 16'h0000, '0, 1'b0, 6'h00);
      $display("test xor_stack done");
      ld(32'habcd_1234);
      wm[0] = 16'h1233;
      wm[1] = 16'h1235;
      wm[2] = 16'h1234;
      for (int i = 0; i < 3; i++) go(compare_word_op, 16'(i), '0, 1'b0, 6'h00);
      go(xor_double_op, 16'h0000, 32'h0000_0001, 1'b1, 6'h00);
      // Empty operation is taken and leaves the accumulator alone
      instr_in       <= '{no_op, 1'b0, 16'h0000, $urandom, 6'h00};
      instr_valid_in <= 1'b1;
      @(posedge clk_in);
      instr_valid_in <= 1'b0;
      repeat (3) @(posedge clk_in);
      chk("no_op accum", am, accum_out);
      $display("test compare done");
      rd(REG_IRQ_STATUS, 32'h0000_0007);
      chk("irq", 32'h0, 32'(irq_out));
      wr(REG_IRQ_ENABLE, 32'h0000_0002);
      chk("irq", 32'h1, 32'(irq_out));
      wr(REG_IRQ_CLEAR, 32'h0000_0002);
      chk("irq", 32'h0, 32'(irq_out));
      rd(REG_IRQ_STATUS, 32'h0000_0005);
      wr(REG_ACC, 32'h5555_aaaa);
      rd(REG_ACC, am);
      rd(REG_FLAGS, 32'(fm));
      rd(REG_STACK, 32'(stk.size()));
      rd(8'h1c, 32'h0000_0000);
      wr(REG_CTRL, 32'h0000_0000);
      chk("ready", 32'h0, 32'(instr_ready_out));
      wr(REG_CTRL, 32'h0000_0001);
      $display("test registers done");
      end_sim();
   end
endmodule
`default_nettype wire
